/* common/scke_pkg.sv */
// Shared constants for the clock-enable state control of a synchronous DRAM.
// Assumes one system clock at 125 MHz on both ends; the memory clock is driven by the controller.
// Overview of operation
// - In self-refresh, high clock-enable only starts exit
// - In power-down, high clock-enable only means exit
// - Rising clock-enable re-enables inputs without clock edge
// - Controller waits setup interval after exit condition
// - Low-power entry only with all banks idle
// - Falling clock-enable elsewhere starts suspend next cycle
// - Suspend holds while low, ends after rising
// - Suspend in recovery only after exit interval
// - Power-down held while low, rising exits idle
// - Other idle commands follow general command decoding
package scke_pkg;

    localparam int CLK_PERIOD_PS           = 8000;
    localparam int ROW_CYCLE_TIME_PS       = 60000;
    localparam int SELF_REFRESH_EXIT_TIME_PS = 70000;
    localparam int EXIT_SETUP_TIME_PS      = 1500;
    localparam int CLK_DIV_HALF            = 4;

    // Least times round up to whole cycles, never under one
    localparam int ROW_CYCLE_CYC =
        (ROW_CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SREX_CYC =
        (SELF_REFRESH_EXIT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SETUP_CYC_RAW =
        (EXIT_SETUP_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int EXIT_SETUP_CYC = (SETUP_CYC_RAW < 1) ? 1 : SETUP_CYC_RAW;
    localparam int CNT_W = 8;

    // Command pin encodings {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP     = 4'h7;
    localparam logic [3:0] CMD_REFRESH = 4'h1;
    localparam logic [3:0] CMD_ACT     = 4'h3;
    localparam logic [3:0] CMD_READ    = 4'h5;

    typedef enum logic [2:0] {
        SCKE_IDLE      = 3'b000,
        SCKE_ACTIVE    = 3'b001,
        SCKE_SUSPEND   = 3'b011,
        SCKE_REFRESH   = 3'b010,
        SCKE_SELF_REF  = 3'b110,
        SCKE_SR_RECOV  = 3'b111,
        SCKE_PWR_DOWN  = 3'b101,
        SCKE_ILLEGAL   = 3'b100
    } scke_state_type;

    // Deselect, or ras_n and cas_n both high whatever we_n (no-operation included)
    function automatic logic scke_is_nop(input logic [3:0] cmd);
        scke_is_nop = cmd[3] | (cmd[2:1] == 2'b11);
    endfunction

endpackage

/* common/scke_if.sv */
// Pin bundle between memory controller and memory device.
// Assumes the controller drives every signal; the device only listens.
`timescale 1ns/1ns
interface scke_if;
    logic       mem_clk;
    logic       cke;
    logic       cs_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;

    modport ctrl (output mem_clk, output cke, output cs_n, output ras_n,
                  output cas_n, output we_n);
    modport dev  (input mem_clk, input cke, input cs_n, input ras_n,
                  input cas_n, input we_n);
endinterface

/* logic/scke_sync.sv */
// Two-flop synchroniser for a pin level.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/1ns
module scke_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    // Level
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule

/* logic/scke_dev.sv */
// Memory device end: tracks the clock-enable state per memory clock edge.
// Assumes the controller keeps its own timing; pins sampled through synchronisers.
`timescale 1ns/1ns
module scke_dev
    import scke_pkg::*;
#(
    parameter int ROW_CYC = ROW_CYCLE_CYC
) (
    // Clock and reset
    input  wire logic           clk_i,
    input  wire logic           nrst_i,
    // Memory pins
    scke_if.dev                 mem,
    // Bank status from the array
    input  wire logic           banks_idle_i,
    input  wire logic           busy_done_i,
    // State report
    output scke_state_type      state_o,
    output logic                inputs_on_o,
    output logic                cmd_valid_o,
    output logic [3:0]          cmd_o,
    output logic                illegal_o
);
    logic [4:0]       pins_s;
    logic             clk_q;
    logic             cke_prev;
    logic             edge_seen;
    logic [CNT_W-1:0] rc_cnt;
    scke_state_type   state;
    scke_state_type   next_state;
    logic             next_illegal;
    logic [3:0]       cmd;
    logic             cke_now;

    scke_sync #(.W(5)) u_pins (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    ({mem.mem_clk, mem.cke, mem.cs_n, mem.ras_n, mem.cas_n}),
        .q_o    (pins_s)
    );

    logic we_s;
    logic we_m;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            we_m <= 1'b1;
            we_s <= 1'b1;
        end else begin
            we_m <= mem.we_n;
            we_s <= we_m;
        end
    end

    assign cmd     = {pins_s[2:0], we_s};
    assign cke_now = pins_s[3];

    ////////////////////////////////////////////////////////////////////////////
    // Memory clock edge detection
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clk_q <= 1'b0;
        end else begin
            clk_q <= pins_s[4];
        end
    end
    assign edge_seen = pins_s[4] & ~clk_q;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cke_prev <= 1'b1;
        end else if (edge_seen) begin
            cke_prev <= cke_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock-enable state decoding
    always_comb begin
        next_state   = state;
        next_illegal = 1'b0;
        case (state)
            SCKE_SELF_REF: begin
                if (cke_prev && !cke_now) begin
                    next_state = SCKE_SELF_REF;
                end else if (!cke_prev && cke_now) begin
                    if (scke_is_nop(cmd)) begin
                        next_state = SCKE_SR_RECOV;
                    end else begin
                        next_illegal = 1'b1;
                    end
                end
            end
            SCKE_SR_RECOV: begin
                if (!scke_is_nop(cmd) && cke_prev) begin
                    next_illegal = 1'b1;
                end
                if (cke_prev && !cke_now) begin
                    next_illegal = next_illegal | (rc_cnt < CNT_W'(SREX_CYC));
                end else if (cke_prev && rc_cnt >= CNT_W'(ROW_CYC)) begin
                    next_state = SCKE_IDLE;
                end
            end
            SCKE_PWR_DOWN: begin
                if (!cke_prev && cke_now) begin
                    next_state = SCKE_IDLE;
                end
            end
            SCKE_IDLE: begin
                if (!cke_prev) begin
                    next_state = SCKE_PWR_DOWN;
                end else if (cmd == CMD_REFRESH) begin
                    next_state = cke_now ? SCKE_REFRESH : SCKE_SELF_REF;
                end else if (!banks_idle_i) begin
                    next_state = SCKE_ACTIVE;
                end
            end
            SCKE_REFRESH: begin
                if (rc_cnt >= CNT_W'(ROW_CYC)) begin
                    next_state = SCKE_IDLE;
                end
            end
            SCKE_ACTIVE: begin
                if (cke_prev && !cke_now) begin
                    next_state = SCKE_SUSPEND;
                end else if (busy_done_i && banks_idle_i) begin
                    next_state = SCKE_IDLE;
                end
            end
            SCKE_SUSPEND: begin
                if (!cke_prev && cke_now) begin
                    next_state = SCKE_ACTIVE;
                end
            end
            default: begin
                next_state = SCKE_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= SCKE_IDLE;
        end else if (edge_seen) begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            illegal_o <= 1'b0;
        end else begin
            illegal_o <= edge_seen & next_illegal;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rc_cnt <= '0;
        end else if (edge_seen) begin
            if (next_state != state) begin
                rc_cnt <= '0;
            end else if (rc_cnt != '1) begin
                rc_cnt <= rc_cnt + CNT_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command hand-off and input buffer enable
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cmd_valid_o <= 1'b0;
            cmd_o       <= CMD_NOP;
        end else begin
            cmd_valid_o <= edge_seen & cke_prev & !next_illegal &
                           (state == SCKE_IDLE || state == SCKE_ACTIVE) &
                           !(state == SCKE_IDLE && cmd == CMD_REFRESH);
            cmd_o       <= cmd;
        end
    end

    // Buffers follow the clock-enable level itself, not a clock edge
    assign inputs_on_o = cke_now |
        !(state == SCKE_SELF_REF || state == SCKE_PWR_DOWN ||
          state == SCKE_SUSPEND);
    assign state_o = state;
endmodule

/* logic/scke_ctrl.sv */
// Memory controller end: makes the memory clock and sequences clock-enable.
// Assumes user requests are held until acknowledged.
`timescale 1ns/1ns
module scke_ctrl
    import scke_pkg::*;
(
    // Clock and reset
    input  wire logic  clk_i,
    input  wire logic  nrst_i,
    // Memory pins
    scke_if.ctrl       mem,
    // User requests
    input  wire logic  banks_idle_i,
    input  wire logic  req_self_ref_i,
    input  wire logic  req_pwr_down_i,
    input  wire logic  req_suspend_i,
    input  wire logic  req_wake_i,
    output logic       busy_o,
    output logic       low_power_o
);
    logic [2:0]       div;
    logic             fall;
    logic [CNT_W-1:0] wait_cnt;
    scke_state_type   st;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div         <= '0;
            mem.mem_clk <= 1'b0;
        end else if (div == 3'(CLK_DIV_HALF - 1)) begin
            div         <= '0;
            mem.mem_clk <= ~mem.mem_clk;
        end else begin
            div <= div + 3'(1);
        end
    end
    // Pins change on the falling memory clock, mid-cycle for the device
    assign fall = (div == 3'(CLK_DIV_HALF - 1)) & mem.mem_clk;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st       <= SCKE_IDLE;
            mem.cke  <= 1'b1;
            wait_cnt <= '0;
            {mem.cs_n, mem.ras_n, mem.cas_n, mem.we_n} <= CMD_NOP;
        end else if (fall) begin
            {mem.cs_n, mem.ras_n, mem.cas_n, mem.we_n} <= CMD_NOP;
            if (wait_cnt != '0) begin
                wait_cnt <= wait_cnt - CNT_W'(1);
            end
            case (st)
                SCKE_IDLE: begin
                    if (banks_idle_i && req_self_ref_i) begin
                        mem.cke <= 1'b0;
                        {mem.cs_n, mem.ras_n, mem.cas_n, mem.we_n} <= CMD_REFRESH;
                        st <= SCKE_SELF_REF;
                    end else if (banks_idle_i && req_pwr_down_i) begin
                        mem.cke <= 1'b0;
                        st <= SCKE_PWR_DOWN;
                    end else if (req_suspend_i && !banks_idle_i) begin
                        mem.cke <= 1'b0;
                        st <= SCKE_SUSPEND;
                    end
                end
                SCKE_SELF_REF, SCKE_PWR_DOWN, SCKE_SUSPEND: begin
                    if (req_wake_i) begin
                        mem.cke  <= 1'b1;
                        wait_cnt <= (st == SCKE_SELF_REF) ?
                            CNT_W'(ROW_CYCLE_CYC + 1) : CNT_W'(EXIT_SETUP_CYC);
                        st <= SCKE_SR_RECOV;
                    end
                end
                SCKE_SR_RECOV: begin
                    if (wait_cnt == '0) begin
                        st <= SCKE_IDLE;
                    end
                end
                default: begin
                    st <= SCKE_IDLE;
                end
            endcase
        end
    end

    assign busy_o      = (st != SCKE_IDLE);
    assign low_power_o = ~mem.cke;
endmodule

/* tb/scke_properties.sv */
// Concurrent checks on the pins between both ends and on the device report.
// Assumes one system clock and an active-low asynchronous reset.
`timescale 1ns/1ns
module scke_properties
    import scke_pkg::*;
(
    // Clock and reset
    input wire logic           clk_i,
    input wire logic           nrst_i,
    // Memory pins
    input wire logic           mem_clk,
    input wire logic           cke,
    input wire logic           cs_n,
    input wire logic           ras_n,
    input wire logic           cas_n,
    input wire logic           we_n,
    // End status
    input wire logic           banks_idle_i,
    input wire logic           low_power_o,
    input wire logic           inputs_on_o,
    input wire scke_state_type state_o,
    input wire logic           illegal_o,
    input wire logic           cmd_valid_o,
    input wire logic [3:0]     cmd_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    wire [3:0] pins = {cs_n, ras_n, cas_n, we_n};
    ////////////////////////////////////////////////////////////////////////////
    property p_lp_level; low_power_o == !cke; endproperty
    a_lp_level: assert property (p_lp_level) else $error("low power flag off");
    property p_inputs_on; $past(cke, 2) |-> inputs_on_o; endproperty
    a_inputs_on: assert property (p_inputs_on) else $error("inputs off with cke");
    property p_pins_on_fall;
        ($changed(pins) || $changed(cke)) |-> $fell(mem_clk);
    endproperty
    a_pins_on_fall: assert property (p_pins_on_fall) else $error("pin change off fall");
    property p_sr_entry_idle;
        ($fell(cke) && pins == CMD_REFRESH) |-> $past(banks_idle_i);
    endproperty
    a_sr_entry_idle: assert property (p_sr_entry_idle) else $error("entry, banks busy");
    property p_sr_exit;
        ($past(nrst_i) && $past(state_o) == SCKE_SELF_REF && state_o != SCKE_SELF_REF)
            |-> state_o == SCKE_SR_RECOV;
    endproperty
    a_sr_exit: assert property (p_sr_exit) else $error("self refresh exit wrong");
    property p_pd_exit;
        ($past(nrst_i) && $past(state_o) == SCKE_PWR_DOWN && state_o != SCKE_PWR_DOWN)
            |-> state_o == SCKE_IDLE;
    endproperty
    a_pd_exit: assert property (p_pd_exit) else $error("power down exit wrong");
    property p_pd_hold;
        (state_o == SCKE_PWR_DOWN && !cke && $past(cke, 8) == 1'b0)
            |=> state_o == SCKE_PWR_DOWN;
    endproperty
    a_pd_hold: assert property (p_pd_hold) else $error("power down not held");
    property p_sr_recov;
        $rose(state_o == SCKE_SR_RECOV)
            |-> (state_o == SCKE_SR_RECOV) [*8] ##[1:40] state_o == SCKE_IDLE;
    endproperty
    a_sr_recov: assert property (p_sr_recov) else $error("recovery length wrong");
    property p_sr_entry_dev; $rose(state_o == SCKE_SELF_REF) |-> !cke; endproperty
    a_sr_entry_dev: assert property (p_sr_entry_dev) else $error("entry with cke high");
    property p_no_illegal; !illegal_o; endproperty
    a_no_illegal: assert property (p_no_illegal) else $error("illegal flagged");
    property p_cmd_no_ref; cmd_valid_o |-> cmd_o != CMD_REFRESH; endproperty
    a_cmd_no_ref: assert property (p_cmd_no_ref) else $error("refresh handed on");
endmodule

/* tb/scke_bench.sv */
// Bench joining controller and device ends through the pin interface.
// Assumes the checker sits beside the interface; requests are held until busy moves.
`timescale 1ns/1ns
module scke_bench
    import scke_pkg::*;
;
    logic           clk_i;
    logic           nrst_i;
    logic           banks_idle;
    logic           busy_done;
    logic [3:0]     req;
    wire            busy;
    wire            low_power;
    wire            inputs_on;
    wire            illegal;
    wire            cmd_valid;
    wire [3:0]      cmd_seen;
    scke_state_type state;
    integer         fail_count;
    integer         cmp_count;
    integer         seed;
    scke_if mem_bus ();
    scke_ctrl scke_ctrl_inst (.clk_i(clk_i), .nrst_i(nrst_i), .mem(mem_bus),
        .banks_idle_i(banks_idle), .req_self_ref_i(req[0]), .req_pwr_down_i(req[1]),
        .req_suspend_i(req[2]), .req_wake_i(req[3]), .busy_o(busy), .low_power_o(low_power));
    scke_dev #(.ROW_CYC(2)) scke_dev_inst (.clk_i(clk_i), .nrst_i(nrst_i), .mem(mem_bus),
        .banks_idle_i(banks_idle), .busy_done_i(busy_done), .state_o(state),
        .inputs_on_o(inputs_on), .cmd_valid_o(cmd_valid), .cmd_o(cmd_seen),
        .illegal_o(illegal));
    scke_properties scke_properties_inst (.clk_i(clk_i), .nrst_i(nrst_i),
        .mem_clk(mem_bus.mem_clk), .cke(mem_bus.cke), .cs_n(mem_bus.cs_n),
        .ras_n(mem_bus.ras_n), .cas_n(mem_bus.cas_n), .we_n(mem_bus.we_n),
        .banks_idle_i(banks_idle), .low_power_o(low_power), .inputs_on_o(inputs_on),
        .state_o(state), .illegal_o(illegal), .cmd_valid_o(cmd_valid), .cmd_o(cmd_seen));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic chk_state(input scke_state_type got, input scke_state_type exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic exp_take(input int k, input logic idle);
        return (k < 2) ? idle : !idle;
    endfunction
    task automatic wait_state(input scke_state_type s);
        int n;
        n = 0;
        while (state !== s && n < 200) begin
            @(posedge clk_i) #1;
            n++;
        end
        chk_state(state, s);
    endtask
    task automatic request(input int idx, output logic taken);
        logic b0;
        int   n;
        b0 = busy;
        n = 0;
        @(posedge clk_i);
        req[idx] <= 1'b1;
        #1;
        while (busy === b0 && n < 200) begin
            @(posedge clk_i) #1;
            n++;
        end
        taken = (busy !== b0);
        @(posedge clk_i);
        req[idx] <= 1'b0;
        #1;
    endtask
    task automatic run_case(input int k, input logic idle);
        logic t;
        @(posedge clk_i);
        banks_idle <= idle;
        request(k, t);
        chk_pin({3'b000, t}, {3'b000, exp_take(k, idle)});
        if (t === 1'b1) begin
            chk_pin({3'b000, mem_bus.cke}, 4'h0);
            if (k == 0) chk_pin({mem_bus.cs_n, mem_bus.ras_n, mem_bus.cas_n,
                mem_bus.we_n}, CMD_REFRESH);
            if (k < 2) begin
                wait_state(k == 0 ? SCKE_SELF_REF : SCKE_PWR_DOWN);
                chk_pin({3'b000, inputs_on}, 4'h0);
                repeat (24) @(posedge clk_i);
                #1;
                chk_state(state, k == 0 ? SCKE_SELF_REF : SCKE_PWR_DOWN);
            end
            request(3, t);
            chk_pin({3'b000, t, low_power}, 4'h2);
            if (k < 2) wait_state(SCKE_IDLE);
        end
    endtask
    initial begin
        seed = 19;
        fail_count = 0;
        cmp_count = 0;
        nrst_i = 1'b0;
        req = 4'h0;
        banks_idle = 1'b1;
        busy_done = 1'b1;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        #1;
        chk_pin({mem_bus.cke, busy, 2'b00}, 4'h8);
        chk_state(state, SCKE_IDLE);
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 2; i++) begin
                run_case(k, i[0]);
            end
        end
        repeat (6) run_case($unsigned($random(seed)) % 3, $random(seed));
        report_and_stop;
    end
    initial begin
        #(8 * 20000);
        fail_count++;
        report_and_stop;
    end
endmodule
